//--- core/tle_channel.sv
// one remote channel: limits, latest reading, sticky exceeded flags
`timescale 1ns/100ps
`default_nettype none
module tle_channel
   import tle_pkg::*;
(
   input  wire logic       mclk,       // clock
   input  wire logic       rst_n,      // async reset, active low
   input  wire logic       wrCfg,      // write to config/status
   input  wire logic       wrHigh,     // write to high limit
   input  wire logic       wrLow,      // write to low limit
   input  wire logic       wrOt,       // write to overtemp limit
   input  wire logic [7:0] wData,      // write data
   input  wire logic       convDone,   // conversion of this channel finished
   input  wire logic [7:0] convVal,    // new result
   output logic      [7:0] cfgStat,    // config/status image
   output logic      [7:0] reading,    // latest reading
   output logic      [7:0] highLim,    // high limit
   output logic      [7:0] lowLim,     // low limit
   output logic      [7:0] otLim       // overtemp limit
);
   // ==================================================
   // limit, reading, flag and enable registers, compare hits
   logic [7:0] highLim_r;  // high limit
   logic [7:0] lowLim_r;   // low limit
   logic [7:0] otLim_r;    // overtemp limit
   logic [7:0] reading_r;  // last result
   logic [2:0] flags_r;    // ot, high, low
   logic [2:0] ctrl_r;     // chen, oten, alen
   logic [2:0] hit;        // violations of the new result

   // limit writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         highLim_r <= RST_HIGH;
         lowLim_r  <= RST_LOW;
         otLim_r   <= RST_OT;
      end else begin
         if (wrHigh) highLim_r <= wData;
         if (wrLow)  lowLim_r  <= wData;
         if (wrOt)   otLim_r   <= wData;
      end
   end

   // result store, readable at any time
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reading_r <= RST_READING;
      end else if (convDone) begin
         reading_r <= convVal;
      end
   end

   // signed compare of the fresh result
   always_comb begin
      hit[CFS_OT]   = $signed(convVal) > $signed(otLim_r);
      hit[CFS_HIGH] = $signed(convVal) > $signed(highLim_r);
      hit[CFS_LOW]  = $signed(convVal) < $signed(lowLim_r);
   end

   // sticky flags: set once per conversion, w1c, set beats clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= RST_CFGSTAT[2:0];
      end else begin
         flags_r <= (flags_r & ~(wrCfg ? wData[2:0] : 3'h0))
                    | (convDone ? hit : 3'h0);
      end
   end

   // enable bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= RST_CFGSTAT[5:3];
      end else if (wrCfg) begin
         ctrl_r <= wData[5:3];
      end
   end

   assign cfgStat = {2'b00, ctrl_r, flags_r};
   assign reading = reading_r;
   assign highLim = highLim_r;
   assign lowLim  = lowLim_r;
   assign otLim   = otLim_r;
endmodule : tle_channel
`default_nettype wire

//--- core/tle_pkg.sv
// package: register map, field positions, reset values and timing for the temp limit block
package tle_pkg;
   // ==================================================
   // register offsets (byte addresses, 16-byte window)
   localparam logic [3:0] OFS_EVT_STATUS  = 4'h0;  // temp_event_status_reg
   localparam logic [3:0] OFS_MGMT_EN     = 4'h2;  // temp_event_mgmt_enable_reg
   localparam logic [3:0] OFS_IRQ_EN      = 4'h4;  // temp_event_irq_enable_reg
   localparam logic [3:0] OFS_SENSOR_CFG  = 4'h8;  // sensor_config_reg
   localparam logic [3:0] OFS_BANK_SEL    = 4'h9;  // bank_select_reg
   localparam logic [3:0] OFS_CH_CFGSTAT  = 4'ha;  // channel_config_status_reg
   localparam logic [3:0] OFS_READING     = 4'hb;  // reading_reg
   localparam logic [3:0] OFS_HIGH_LIMIT  = 4'hc;  // high_limit_reg
   localparam logic [3:0] OFS_LOW_LIMIT   = 4'hd;  // low_limit_reg
   localparam logic [3:0] OFS_OT_LIMIT    = 4'he;  // overtemp_limit_reg
   localparam logic [3:0] OFS_SIM_RESULT  = 4'hf;  // conversion result feed, not decoded: writes ignored, reads as zero
   // ==================================================
   // channel config/status field positions
   localparam int CFS_LOW    = 0;  // low limit exceeded, w1c
   localparam int CFS_HIGH   = 1;  // high limit exceeded, w1c
   localparam int CFS_OT     = 2;  // overtemp limit exceeded, w1c
   localparam int CFS_ALEN   = 3;  // alert output enable
   localparam int CFS_OTEN   = 4;  // shutdown output enable
   localparam int CFS_CHEN   = 5;  // channel enable
   // sensor config field positions
   localparam int CFG_STBY   = 0;  // standby mode
   // ==================================================
   // reset values
   localparam logic [7:0] RST_CFGSTAT   = 8'h00;
   localparam logic [7:0] RST_SENSORCFG = 8'h01;  // standby set by default
   localparam logic [7:0] RST_HIGH      = 8'h7f;  // +127 C
   localparam logic [7:0] RST_LOW       = 8'hc9;  // -55 C
   localparam logic [7:0] RST_OT        = 8'h7f;  // +127 C
   localparam logic [7:0] RST_READING   = 8'h00;  // 0 C
   // ==================================================
   // timing
   localparam int CLK_MHZ     = 100;
   localparam int CONV_NS     = 1000;  // time for one channel conversion
   localparam int CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int WAKE_NS     = 2000;  // wake-up sequence after sleep input returns
   localparam int WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int NUM_CH      = 2;

   typedef enum logic [1:0] {
      CV_IDLE = 2'b00,  // not converting
      CV_WAKE = 2'b01,  // wake-up sequence
      CV_RUN  = 2'b11   // converting a channel
   } tle_conv_t;
endpackage : tle_pkg

//--- core/tle_top.sv
// top: APB register window, conversion sequencer and event outputs
`timescale 1ns/100ps
`default_nettype none
module tle_top
   import tle_pkg::*;
(
   input  wire logic        mclk,           // clock, 100 MHz
   input  wire logic        rst_n,          // async reset, active low
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb access phase
   input  wire logic        pwrite,         // apb direction
   input  wire logic [11:0] paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   output logic      [31:0] prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        sleepStateIn,   // sleep state input, high = awake
   input  wire logic        adcValid,       // converter result strobe, pin side
   input  wire logic [7:0]  adcData,        // converter result, pin side
   output logic             alertOut_n,     // window alert, active low
   output logic             otShutdownOut_n,// combined shutdown, active low
   output logic             shutdownCh1_n,  // channel 1 shutdown, active low
   output logic             shutdownCh2_n,  // channel 2 shutdown, active low
   output logic             mgmtIntOut_n,   // management interrupt, active low
   output logic             irqOut,         // irq, active high
   output logic             convActive,     // converter running
   output logic             convChan        // channel being converted
);
   // ==================================================
   // pin synchronisers
   logic [1:0] sleepSync_r;  // sleep input sync
   logic [1:0] vldSync_r;    // result strobe sync
   logic [7:0] dat1_r;       // result sync stage 1
   logic [7:0] dat2_r;       // result sync stage 2
   logic       vldD_r;       // strobe edge history

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sleepSync_r <= 2'b00;
         vldSync_r   <= 2'b00;
         dat1_r      <= 8'h00;
         dat2_r      <= 8'h00;
         vldD_r      <= 1'b0;
      end else begin
         sleepSync_r <= {sleepSync_r[0], sleepStateIn};
         vldSync_r   <= {vldSync_r[0], adcValid};
         dat1_r      <= adcData;
         dat2_r      <= dat1_r;
         vldD_r      <= vldSync_r[1];
      end
   end
   wire awake   = sleepSync_r[1];
   wire extDone = vldSync_r[1] & ~vldD_r;  // rising edge of result strobe

   // ==================================================
   // apb decode
   logic [7:0] bank_r;       // bank select
   logic [7:0] cfg_r;        // sensor config
   logic [3:0] mgmtEn_r;     // mgmt enables
   logic [3:0] irqEn_r;      // irq enables
   logic [3:0] evt_r;        // event status
   logic [7:0] rdMux;        // read mux

   wire        acc    = psel & penable;
   wire        wrAcc  = acc & pwrite;
   wire [3:0]  ofs    = paddr[3:0];
   wire        inWin  = (paddr[11:4] == 8'h00);
   wire        banked = (ofs >= OFS_CH_CFGSTAT);
   wire        bankOk = (bank_r < 8'(NUM_CH));
   wire        sel1   = (bank_r == 8'h00);
   wire        wrOk   = wrAcc & inWin;

   // per-channel write strobes
   logic [NUM_CH-1:0] wCfg;   // config/status strobe
   logic [NUM_CH-1:0] wHigh;  // high limit strobe
   logic [NUM_CH-1:0] wLow;   // low limit strobe
   logic [NUM_CH-1:0] wOt;    // ot limit strobe
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         wCfg[i]  = wrOk && bankOk && (bank_r == 8'(i)) && ofs == OFS_CH_CFGSTAT;
         wHigh[i] = wrOk && bankOk && (bank_r == 8'(i)) && ofs == OFS_HIGH_LIMIT;
         wLow[i]  = wrOk && bankOk && (bank_r == 8'(i)) && ofs == OFS_LOW_LIMIT;
         wOt[i]   = wrOk && bankOk && (bank_r == 8'(i)) && ofs == OFS_OT_LIMIT;
      end
   end

   // ==================================================
   // conversion sequencer
   tle_conv_t  st_r;         // sequencer state
   logic [15:0] cnt_r;       // cycle counter
   logic        ch_r;        // current channel
   logic [7:0]  cv0, cv1;    // config images
   wire         stby = cfg_r[CFG_STBY];
   wire         en0  = cv0[CFS_CHEN];
   wire         en1  = cv1[CFS_CHEN];
   wire         anyEn = en0 | en1;
   wire         runOk = awake & ~stby & anyEn;
   wire         timerDone = (st_r == CV_RUN) && (cnt_r == 16'(CONV_CYC - 1));
   wire         done = (st_r == CV_RUN) && (extDone || timerDone);
   // next channel: alternate, skipping a disabled one
   wire         nxtCh = ch_r ? (en0 ? 1'b0 : 1'b1) : (en1 ? 1'b1 : 1'b0);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r  <= CV_IDLE;
         cnt_r <= 16'h0000;
         ch_r  <= 1'b0;
      end else begin
         case (st_r)
            CV_IDLE: begin  // wait for wake, standby off and a channel
               cnt_r <= 16'h0000;
               if (runOk) st_r <= CV_WAKE;
            end
            CV_WAKE: begin  // wake-up sequence
               if (!runOk) begin
                  st_r <= CV_IDLE;
               end else if (cnt_r == 16'(WAKE_CYC - 1)) begin
                  st_r  <= CV_RUN;
                  cnt_r <= 16'h0000;
                  ch_r  <= en0 ? 1'b0 : 1'b1;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            CV_RUN: begin  // convert, then move to the next enabled channel
               if (!runOk) begin
                  st_r <= CV_IDLE;
               end else if (done) begin
                  cnt_r <= 16'h0000;
                  ch_r  <= nxtCh;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            default: st_r <= CV_IDLE;
         endcase
      end
   end

   // result source: converter data on strobe, else zero on timeout
   wire [7:0] convVal = extDone ? dat2_r : 8'h00;
   wire [1:0] chDone  = {done & ch_r, done & ~ch_r};

   // ==================================================
   // channels
   logic [7:0] rd0, rd1, hl0, hl1, ll0, ll1, ol0, ol1;
   tle_channel u_ch1 (
      .mclk(mclk), .rst_n(rst_n), .wrCfg(wCfg[0]), .wrHigh(wHigh[0]),
      .wrLow(wLow[0]), .wrOt(wOt[0]), .wData(pwdata[7:0]), .convDone(chDone[0]),
      .convVal(convVal), .cfgStat(cv0), .reading(rd0), .highLim(hl0),
      .lowLim(ll0), .otLim(ol0)
   );
   tle_channel u_ch2 (
      .mclk(mclk), .rst_n(rst_n), .wrCfg(wCfg[1]), .wrHigh(wHigh[1]),
      .wrLow(wLow[1]), .wrOt(wOt[1]), .wData(pwdata[7:0]), .convDone(chDone[1]),
      .convVal(convVal), .cfgStat(cv1), .reading(rd1), .highLim(hl1),
      .lowLim(ll1), .otLim(ol1)
   );

   // ==================================================
   // common registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bank_r  <= 8'h00;
         cfg_r   <= RST_SENSORCFG;
         mgmtEn_r <= 4'h0;
         irqEn_r <= 4'h0;
      end else if (wrOk) begin
         case (ofs)
            OFS_BANK_SEL:   bank_r  <= pwdata[7:0];
            OFS_SENSOR_CFG: cfg_r   <= {7'h00, pwdata[CFG_STBY]};
            OFS_MGMT_EN:    mgmtEn_r <= pwdata[3:0];
            OFS_IRQ_EN:     irqEn_r <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // event status: follows channel flags, w1c, set beats clear
   wire [3:0] evtSet = {cv1[CFS_OT], cv1[CFS_HIGH] | cv1[CFS_LOW],
                        cv0[CFS_OT], cv0[CFS_HIGH] | cv0[CFS_LOW]};
   wire [3:0] evtClr = (wrOk && ofs == OFS_EVT_STATUS) ? pwdata[3:0] : 4'h0;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evt_r <= 4'h0;
      end else begin
         evt_r <= (evt_r & ~evtClr) | evtSet;
      end
   end

   // ==================================================
   // read mux and apb answer
   always_comb begin
      rdMux = 8'h00;
      case (ofs)
         OFS_EVT_STATUS: rdMux = {4'h0, evt_r};
         OFS_MGMT_EN:    rdMux = {4'h0, mgmtEn_r};
         OFS_IRQ_EN:     rdMux = {4'h0, irqEn_r};
         OFS_SENSOR_CFG: rdMux = cfg_r;
         OFS_BANK_SEL:   rdMux = bank_r;
         OFS_CH_CFGSTAT: rdMux = sel1 ? cv0 : cv1;
         OFS_READING:    rdMux = sel1 ? rd0 : rd1;
         OFS_HIGH_LIMIT: rdMux = sel1 ? hl0 : hl1;
         OFS_LOW_LIMIT:  rdMux = sel1 ? ll0 : ll1;
         OFS_OT_LIMIT:   rdMux = sel1 ? ol0 : ol1;
         default:        rdMux = 8'h00;
      endcase
      if (banked && !bankOk) rdMux = 8'h00;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;  // one wait-free access cycle after setup
         pslverr <= psel & ~penable & ~inWin;
         prdata  <= (psel & ~penable & ~pwrite & inWin) ? {24'h000000, rdMux} : 32'h0;
      end
   end

   // ==================================================
   // event outputs, all registered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alertOut_n      <= 1'b1;
         otShutdownOut_n <= 1'b1;
         shutdownCh1_n   <= 1'b1;
         shutdownCh2_n   <= 1'b1;
         mgmtIntOut_n    <= 1'b1;
         irqOut          <= 1'b0;
         convActive      <= 1'b0;
         convChan        <= 1'b0;
      end else begin
         alertOut_n <= ~((cv0[CFS_ALEN] & (cv0[CFS_HIGH] | cv0[CFS_LOW]))
                       | (cv1[CFS_ALEN] & (cv1[CFS_HIGH] | cv1[CFS_LOW])));
         shutdownCh1_n   <= ~(cv0[CFS_OTEN] & cv0[CFS_OT]);
         shutdownCh2_n   <= ~(cv1[CFS_OTEN] & cv1[CFS_OT]);
         otShutdownOut_n <= ~((cv0[CFS_OTEN] & cv0[CFS_OT])
                            | (cv1[CFS_OTEN] & cv1[CFS_OT]));
         mgmtIntOut_n <= ~|(evt_r & mgmtEn_r);
         irqOut       <= |(evt_r & irqEn_r);
         convActive   <= (st_r == CV_RUN);
         convChan     <= ch_r;
      end
   end
endmodule : tle_top
`default_nettype wire

//--- tb/tle_adc_model.sv
// converter partner: one result strobe per conversion
`timescale 1ns/100ps
`default_nettype none
module tle_adc_model #(
   parameter int DLY = 6  // cycles to result
) (
   input  wire logic       mclk,       // clock
   input  wire logic       convActive, // converting
   input  wire logic       convChan,   // channel
   input  wire logic [7:0] temp1,      // remote 1 value
   input  wire logic [7:0] temp2,      // remote 2 value
   output logic            adcValid,   // result strobe
   output logic      [7:0] adcData     // result
);
   // ====
   // answer well inside the timeout, data held across the strobe
   initial begin
      adcValid = 1'b0;
      adcData = 8'h00;
   end
   always begin
      @(posedge mclk);
      if (convActive) begin
         repeat (DLY) @(posedge mclk);
         adcData <= convChan ? temp2 : temp1;
         repeat (2) @(posedge mclk);
         adcValid <= 1'b1;
         repeat (4) @(posedge mclk);
         adcValid <= 1'b0;
         adcData <= ~adcData;  // released, no longer valid
         repeat (6) @(posedge mclk);
      end
   end
endmodule : tle_adc_model
`default_nettype wire

//--- tb/tle_chk.sv
// checker: bus and output relations at the temp limit block ports
`timescale 1ns/100ps
`default_nettype none
module tle_chk (
   input wire logic        mclk,            // clock
   input wire logic        rst_n,           // reset, active low
   input wire logic        psel,            // apb select
   input wire logic        penable,         // apb access
   input wire logic        pwrite,          // apb direction
   input wire logic [11:0] paddr,           // apb address
   input wire logic [31:0] prdata,          // apb read data
   input wire logic        pready,          // apb ready
   input wire logic        pslverr,         // apb error
   input wire logic        sleepStateIn,    // sleep input
   input wire logic        alertOut_n,      // alert
   input wire logic        otShutdownOut_n, // combined shutdown
   input wire logic        shutdownCh1_n,   // ch1 shutdown
   input wire logic        shutdownCh2_n,   // ch2 shutdown
   input wire logic        mgmtIntOut_n,    // mgmt interrupt
   input wire logic        irqOut,          // irq
   input wire logic        convActive       // converting
);
   // ====
   // helper: cycles since the last register write, saturating
   logic [3:0] wrAge_r;  // age counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) wrAge_r <= 4'hf;
      else if (psel && penable && pwrite) wrAge_r <= 4'h0;
      else if (wrAge_r != 4'hf) wrAge_r <= wrAge_r + 4'h1;
   end
   // ====
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready)
      else $error("no ready after setup");
   property p_ready_only; pready |-> psel && penable && !$past(penable); endproperty
   a_ready_only: assert property (p_ready_only)
      else $error("ready outside access");
   property p_err; psel && !penable && paddr[11:4] != 8'h00 |=> pslverr; endproperty
   a_err: assert property (p_err)
      else $error("no error outside window");
   property p_in_win;
      psel && !penable && paddr[11:4] == 8'h00 |=> !pslverr && prdata[31:8] == 24'h0;
   endproperty
   a_in_win: assert property (p_in_win)
      else $error("bad answer inside window");
   property p_comb; otShutdownOut_n == (shutdownCh1_n && shutdownCh2_n); endproperty
   a_comb: assert property (p_comb)
      else $error("combined shutdown mismatch");
   property p_sleep; !sleepStateIn [*5] |-> !convActive; endproperty
   a_sleep: assert property (p_sleep)
      else $error("converting while asleep");
   property p_wake; $rose(sleepStateIn) |=> !convActive [*8]; endproperty
   a_wake: assert property (p_wake)
      else $error("no wake-up delay");
   property p_stby; $rose(rst_n) |-> !convActive [*8]; endproperty
   a_stby: assert property (p_stby)
      else $error("converting after reset");
   property p_alert_hold; $rose(alertOut_n) |-> wrAge_r < 4'h8; endproperty
   a_alert_hold: assert property (p_alert_hold)
      else $error("alert dropped without write");
   property p_sh1_hold; $rose(shutdownCh1_n) |-> wrAge_r < 4'h8; endproperty
   a_sh1_hold: assert property (p_sh1_hold)
      else $error("shutdown dropped without write");
   property p_irq_hold; $fell(irqOut) |-> wrAge_r < 4'h8; endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without write");
   property p_mgmt_hold; $rose(mgmtIntOut_n) |-> wrAge_r < 4'h8; endproperty
   a_mgmt_hold: assert property (p_mgmt_hold)
      else $error("mgmt dropped without write");
endmodule : tle_chk
`default_nettype wire

//--- tb/tle_top_tb_top.sv
// testbench top: register tests over apb with converter partner
`timescale 1ns/100ps
`default_nettype none
module tle_top_tb_top
   import tle_pkg::*;
;
   logic        mclk = 1'b0;    // clock
   logic        rst_n = 1'b0;   // reset
   logic        psel = 1'b0;    // apb
   logic        penable = 1'b0; // apb
   logic        pwrite = 1'b0;  // apb
   logic [11:0] paddr = 12'h0;  // apb
   logic [31:0] pwdata = 32'h0; // apb
   logic [31:0] prdata;         // apb
   logic        pready, pslverr, sleepStateIn = 1'b0, adcValid, convActive, convChan;
   logic        alertOut_n, otShutdownOut_n, shutdownCh1_n, shutdownCh2_n, mgmtIntOut_n, irqOut;
   logic [7:0]  adcData, temp1 = 8'h0, temp2 = 8'h0; // partner values
   logic [31:0] rdVal;          // last read
   logic        rdErr;          // last error
   int          errorCnt = 0, checks = 0;
   always #5 mclk = ~mclk;
   tle_top u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleepStateIn(sleepStateIn), .adcValid(adcValid),
      .adcData(adcData), .alertOut_n(alertOut_n), .otShutdownOut_n(otShutdownOut_n),
      .shutdownCh1_n(shutdownCh1_n), .shutdownCh2_n(shutdownCh2_n),
      .mgmtIntOut_n(mgmtIntOut_n), .irqOut(irqOut), .convActive(convActive),
      .convChan(convChan));
   tle_adc_model u_adc (.mclk(mclk), .convActive(convActive), .convChan(convChan),
      .temp1(temp1), .temp2(temp2), .adcValid(adcValid), .adcData(adcData));
   // ====
   // tasks
   task automatic stopTest;
      $display("checks %0d errors %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stopTest
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // ready, read data and error are taken at the rising edge only
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errorCnt++;
         stopTest();
      end
      @(posedge mclk);
   endtask : apb
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      apb(1'b1, {8'h00, a}, {24'h0, d});
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      apb(1'b0, {8'h00, a}, 32'h0);
      chk(rdVal, {24'h0, e});
   endtask : rd
   task automatic poll(input logic [3:0] a, input logic [7:0] e);
      int i;
      for (i = 0; i < 60; i++) begin
         apb(1'b0, {8'h00, a}, 32'h0);
         if (rdVal === {24'h0, e}) break;
      end
      chk(rdVal, {24'h0, e});
      if (i == 60) stopTest();
   endtask : poll
   task automatic pins(input logic [5:0] e);
      @(negedge mclk);
      chk({26'h0, alertOut_n, otShutdownOut_n, shutdownCh1_n, shutdownCh2_n,
           mgmtIntOut_n, irqOut}, {26'h0, e});
      @(posedge mclk);
   endtask : pins
   task automatic waitConv(input logic e);
      int i;
      i = 0;
      do begin
         @(negedge mclk);
         i++;
      end while (convActive !== e && i < 400);
      chk({31'h0, convActive}, {31'h0, e});
      if (i >= 400) stopTest();
      @(posedge mclk);
   endtask : waitConv
   // ====
   // hang guard
   initial begin
      repeat (60000) @(posedge mclk);
      errorCnt++;
      stopTest();
   end
   // ====
   // main sequence
   initial begin : main
      int b;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(OFS_EVT_STATUS, 8'h00);
      rd(OFS_SENSOR_CFG, RST_SENSORCFG);
      rd(OFS_BANK_SEL, 8'h00);
      rd(OFS_CH_CFGSTAT, RST_CFGSTAT);
      rd(OFS_READING, RST_READING);
      rd(OFS_HIGH_LIMIT, RST_HIGH);
      rd(OFS_LOW_LIMIT, RST_LOW);
      rd(OFS_OT_LIMIT, RST_OT);
      rd(4'h1, 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      wr(OFS_BANK_SEL, 8'h02);
      wr(OFS_HIGH_LIMIT, 8'h55);
      rd(OFS_HIGH_LIMIT, 8'h00);
      wr(OFS_BANK_SEL, 8'h01);
      rd(OFS_HIGH_LIMIT, RST_HIGH);
      for (b = 0; b < 2; b++) begin
         wr(OFS_BANK_SEL, b[7:0]);
         wr(OFS_HIGH_LIMIT, 8'h19);  // +25 C
         wr(OFS_LOW_LIMIT, 8'h00);   // 0 C
         wr(OFS_OT_LIMIT, 8'h28);    // +40 C
         wr(OFS_CH_CFGSTAT, 8'h38);  // all enables
      end
      wr(OFS_MGMT_EN, 8'h02);
      wr(OFS_IRQ_EN, 8'h04);
      temp1 <= 8'h1e;
      temp2 <= 8'hf6;
      wr(OFS_SENSOR_CFG, 8'h00);
      sleepStateIn <= 1'b1;
      waitConv(1'b1);
      chk({31'h0, convChan}, 32'h0);
      poll(OFS_EVT_STATUS, 8'h05);
      rd(OFS_CH_CFGSTAT, 8'h39);
      wr(OFS_BANK_SEL, 8'h00);
      rd(OFS_CH_CFGSTAT, 8'h3a);
      pins(6'h1f);
      temp1 <= 8'h2d;
      temp2 <= 8'h05;
      poll(OFS_EVT_STATUS, 8'h07);
      poll(OFS_READING, 8'h2d);
      rd(OFS_CH_CFGSTAT, 8'h3e);
      wr(OFS_BANK_SEL, 8'h01);
      poll(OFS_READING, 8'h05);
      rd(OFS_CH_CFGSTAT, 8'h39);
      pins(6'h05);
      sleepStateIn <= 1'b0;
      waitConv(1'b0);
      temp1 <= 8'h50;
      temp2 <= 8'h50;
      repeat (40) @(posedge mclk);
      rd(OFS_READING, 8'h05);
      wr(OFS_CH_CFGSTAT, 8'h38);
      rd(OFS_CH_CFGSTAT, 8'h39);
      wr(OFS_CH_CFGSTAT, 8'h39);
      rd(OFS_CH_CFGSTAT, 8'h38);
      wr(OFS_BANK_SEL, 8'h00);
      wr(OFS_CH_CFGSTAT, 8'h3f);
      rd(OFS_CH_CFGSTAT, 8'h38);
      wr(OFS_EVT_STATUS, 8'h0f);
      rd(OFS_EVT_STATUS, 8'h00);
      pins(6'h3e);
      wr(OFS_SENSOR_CFG, 8'h01);
      sleepStateIn <= 1'b1;
      repeat (WAKE_CYC + 50) @(negedge mclk);
      chk({31'h0, convActive}, 32'h0);
      stopTest();
   end
endmodule : tle_top_tb_top
bind tle_top tle_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleepStateIn(sleepStateIn), .alertOut_n(alertOut_n),
   .otShutdownOut_n(otShutdownOut_n), .shutdownCh1_n(shutdownCh1_n),
   .shutdownCh2_n(shutdownCh2_n), .mgmtIntOut_n(mgmtIntOut_n), .irqOut(irqOut),
   .convActive(convActive));
`default_nettype wire
